/* rtl/csb_pkg.sv */
`default_nettype none
package csb_pkg;
  localparam logic [7:0] CSB_STATUS_SECOND_OFS = 8'h96;
  localparam logic [7:0] CSB_EVENT_FLAGS_OFS = 8'h97;
  localparam logic [7:0] CSB_EVENT_ENABLES_OFS = 8'h98;
  localparam logic [7:0] CSB_RSVD_FIRST_OFS = 8'h99;
  localparam logic [7:0] CSB_RSVD_LAST_OFS = 8'h9f;
  // status second bit positions
  localparam int CSB_ST_ANTI_SWELL = 0;
  localparam int CSB_ST_THERM_DIS = 1;
  localparam int CSB_ST_CHARGING = 4;
  localparam int CSB_ST_COMPLETE = 5;
  localparam int CSB_ST_RAIL_LOW = 6;
  localparam int CSB_ST_OVERTEMP = 7;
  // flag / enable bit positions
  localparam int CSB_EV_ADAPTER = 0;
  localparam int CSB_EV_LIMIT = 1;
  localparam int CSB_EV_COMPLETE = 2;
  localparam int CSB_EV_COUNT = 3;
  localparam logic [7:0] CSB_FLAGS_RESET = 8'h00;
  localparam logic [7:0] CSB_ENABLES_RESET = 8'h01;
  // input limit selection codes
  localparam logic [1:0] CSB_LIM_STARTUP = 2'h0;
  localparam logic [1:0] CSB_LIM_REGISTER = 2'h1;
  localparam logic [1:0] CSB_LIM_PIN_LOW = 2'h2;
  localparam logic [1:0] CSB_LIM_PIN_HIGH = 2'h3;
  typedef enum logic [1:0] {
    CSB_CHG_FULL,
    CSB_CHG_REDUCED,
    CSB_CHG_OFF
  } csb_charge_mode_t;
endpackage
`default_nettype wire

/* rtl/csb_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module csb_bank
  import csb_pkg::*;
#(
  parameter int LIMIT_W = 3
) (
  input wire logic clk_sys_i, // 20 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [7:0] reg_addr_i, // register offset
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  input wire logic [7:0] reg_wdata_i, // write data
  output logic [7:0] reg_rdata_o, // read data
  output logic reg_rsvd_wr_o, // write hit reserved range
  input wire logic adapter_present_i, // adapter inserted
  input wire logic input_limit_active_i, // input limiting now
  input wire logic anti_swell_discharging_i, // anti-swell discharge
  input wire logic thermistor_check_disabled_i, // thermistor pin grounded
  input wire logic charging_active_i, // charging in progress
  input wire logic charge_complete_i, // charge cycle done
  input wire logic system_rail_low_i, // rail below 3.6 V comparator
  input wire logic die_overtemp_i, // die above 120 C
  input wire logic input_above_lockout_i, // input above undervoltage_lockout
  input wire logic rail_startup_done_i, // system rail at final value
  input wire logic sys_below_bat_i, // rail about 15 mV below battery
  input wire logic limit_source_internal_i, // config bit7
  input wire logic [LIMIT_W-1:0] limit_setting_field_i, // config limit field
  input wire logic charge_priority_select_i, // special control bit5
  input wire logic limit_select_pin_i, // limit select pin
  output logic [7:0] status_first_o, // first status bits 0 and 7
  output logic irq_o, // combined interrupt request
  output logic [1:0] limit_sel_o, // limit source code
  output logic [LIMIT_W-1:0] limit_code_o, // register limit field applied
  output logic prereg_run_o, // pre-regulator run gate
  output logic [1:0] charge_mode_o, // charge full/reduced/off
  output logic diode_switch_o, // internal ideal diode switch
  output logic ext_diode_gate_pin_o // external diode gate drive
);
  if (LIMIT_W != 3) begin : g_limit_w_check
    $error("limit field must be 3 bits");
  end

  logic [7:0] flags_q;
  logic [7:0] enables_q;
  logic adapter_q;
  logic limit_q;
  logic complete_q;
  logic [CSB_EV_COUNT-1:0] events;
  logic [7:0] status_second;
  logic wr_flags;
  logic wr_enables;
  csb_charge_mode_t mode_d;

  // status bits sit at their fixed positions; bits 3:2 read zero
  always_comb begin
    status_second = 8'h00;
    status_second[CSB_ST_ANTI_SWELL] = anti_swell_discharging_i;
    status_second[CSB_ST_THERM_DIS] = thermistor_check_disabled_i;
    status_second[CSB_ST_CHARGING] = charging_active_i;
    status_second[CSB_ST_COMPLETE] = charge_complete_i;
    status_second[CSB_ST_RAIL_LOW] = system_rail_low_i;
    status_second[CSB_ST_OVERTEMP] = die_overtemp_i;
  end
  assign status_first_o = {input_limit_active_i, 6'h00, adapter_present_i};

  // previous samples for change detection
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      adapter_q <= 1'b0;
      limit_q <= 1'b0;
      complete_q <= 1'b0;
    end else begin
      adapter_q <= adapter_present_i;
      limit_q <= input_limit_active_i;
      complete_q <= charge_complete_i;
    end
  end

  // reset releases without treating the first sample as a change
  logic armed_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) armed_q <= 1'b0;
    else armed_q <= 1'b1;
  end

  assign events[CSB_EV_ADAPTER] = armed_q & (adapter_present_i ^ adapter_q);
  assign events[CSB_EV_LIMIT] = armed_q & (input_limit_active_i ^ limit_q);
  assign events[CSB_EV_COMPLETE] = armed_q & charge_complete_i & ~complete_q;

  assign wr_flags = reg_wr_i && (reg_addr_i == CSB_EVENT_FLAGS_OFS);
  assign wr_enables = reg_wr_i && (reg_addr_i == CSB_EVENT_ENABLES_OFS);

  genvar g;
  generate
    for (g = 0; g < CSB_EV_COUNT; g++) begin : g_flag
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          flags_q[g] <= CSB_FLAGS_RESET[g];
        end else if (events[g]) begin
          flags_q[g] <= 1'b1;
        end else if (wr_flags && reg_wdata_i[g]) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // reserved upper bits are plain read-write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) flags_q[7:CSB_EV_COUNT] <= CSB_FLAGS_RESET[7:CSB_EV_COUNT];
    else if (wr_flags) flags_q[7:CSB_EV_COUNT] <= reg_wdata_i[7:CSB_EV_COUNT];
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) enables_q <= CSB_ENABLES_RESET;
    else if (wr_enables) enables_q <= reg_wdata_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(flags_q[CSB_EV_COUNT-1:0] & enables_q[CSB_EV_COUNT-1:0]);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        CSB_STATUS_SECOND_OFS: reg_rdata_o <= status_second;
        CSB_EVENT_FLAGS_OFS: reg_rdata_o <= flags_q;
        CSB_EVENT_ENABLES_OFS: reg_rdata_o <= enables_q;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // flags a misbehaving controller; the write itself is dropped
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) reg_rsvd_wr_o <= 1'b0;
    else reg_rsvd_wr_o <= reg_wr_i && reg_addr_i >= CSB_RSVD_FIRST_OFS
                          && reg_addr_i <= CSB_RSVD_LAST_OFS;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      limit_sel_o <= CSB_LIM_STARTUP;
      limit_code_o <= '0;
    end else begin
      limit_code_o <= limit_setting_field_i;
      if (!rail_startup_done_i) limit_sel_o <= CSB_LIM_STARTUP;
      else if (limit_source_internal_i) limit_sel_o <= CSB_LIM_REGISTER;
      else if (limit_select_pin_i) limit_sel_o <= CSB_LIM_PIN_HIGH;
      else limit_sel_o <= CSB_LIM_PIN_LOW;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) prereg_run_o <= 1'b0;
    else prereg_run_o <= input_above_lockout_i;
  end

  always_comb begin
    mode_d = CSB_CHG_FULL;
    if (system_rail_low_i) begin
      if (!charge_priority_select_i) mode_d = CSB_CHG_OFF;
      else if (input_limit_active_i) mode_d = CSB_CHG_REDUCED;
      else mode_d = CSB_CHG_REDUCED;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) charge_mode_o <= CSB_CHG_FULL;
    else charge_mode_o <= mode_d;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      diode_switch_o <= 1'b0;
      ext_diode_gate_pin_o <= 1'b0;
    end else begin
      diode_switch_o <= sys_below_bat_i;
      ext_diode_gate_pin_o <= sys_below_bat_i;
    end
  end

  property p_set_wins;
    @(posedge clk_sys_i) disable iff (rst_i)
    events[CSB_EV_ADAPTER] |=> flags_q[CSB_EV_ADAPTER];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_rise_only;
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(charge_complete_i) && !flags_q[CSB_EV_COMPLETE] |=> !flags_q[CSB_EV_COMPLETE];
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("fall set complete flag");

  property p_limit_change;
    @(posedge clk_sys_i) disable iff (rst_i)
    $changed(input_limit_active_i) && armed_q |=> flags_q[CSB_EV_LIMIT];
  endproperty
  a_limit_change: assert property (p_limit_change) else $error("limit flag missed");

  property p_w1c;
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_flags && reg_wdata_i[CSB_EV_ADAPTER] && !events[CSB_EV_ADAPTER]
      |=> !flags_q[CSB_EV_ADAPTER];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_w0_keeps;
    @(posedge clk_sys_i) disable iff (rst_i)
    wr_flags && !reg_wdata_i[CSB_EV_ADAPTER] && flags_q[CSB_EV_ADAPTER] |=> flags_q[CSB_EV_ADAPTER];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("zero write cleared flag");

  property p_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
    flags_q[CSB_EV_ADAPTER] && enables_q[CSB_EV_ADAPTER] |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_startup_limit;
    @(posedge clk_sys_i) disable iff (rst_i)
    !rail_startup_done_i |=> limit_sel_o == CSB_LIM_STARTUP;
  endproperty
  a_startup_limit: assert property (p_startup_limit) else $error("startup limit");

  property p_pin_limit;
    @(posedge clk_sys_i) disable iff (rst_i)
    rail_startup_done_i && !limit_source_internal_i && limit_select_pin_i
      |=> limit_sel_o == CSB_LIM_PIN_HIGH;
  endproperty
  a_pin_limit: assert property (p_pin_limit) else $error("pin limit wrong");

  property p_instant_on;
    @(posedge clk_sys_i) disable iff (rst_i)
    system_rail_low_i && !charge_priority_select_i |=> charge_mode_o == CSB_CHG_OFF;
  endproperty
  a_instant_on: assert property (p_instant_on) else $error("charge not off");

  property p_lockout;
    @(posedge clk_sys_i) disable iff (rst_i)
    !input_above_lockout_i |=> !prereg_run_o;
  endproperty
  a_lockout: assert property (p_lockout) else $error("pre-regulator ran in lockout");

  property p_enable_reset;
    @(posedge clk_sys_i)
    rst_i |=> enables_q == CSB_ENABLES_RESET;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enable reset value");

  property p_adapter_change;
    @(posedge clk_sys_i) disable iff (rst_i)
    $changed(adapter_present_i) && armed_q |=> flags_q[CSB_EV_ADAPTER];
  endproperty
  a_adapter_change: assert property (p_adapter_change) else $error("adapter flag");

  property p_complete_rise;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(charge_complete_i) && armed_q |=> flags_q[CSB_EV_COMPLETE];
  endproperty
  a_complete_rise: assert property (p_complete_rise) else $error("rise missed");

  property p_no_spurious;
    @(posedge clk_sys_i) disable iff (rst_i)
    !flags_q[CSB_EV_COMPLETE] && !events[CSB_EV_COMPLETE] |=> !flags_q[CSB_EV_COMPLETE];
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set without event");

  property p_irq_low;
    @(posedge clk_sys_i) disable iff (rst_i)
    !(|(flags_q[CSB_EV_COUNT-1:0] & enables_q[CSB_EV_COUNT-1:0])) |=> !irq_o;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq without enabled flag");

  property p_register_limit;
    @(posedge clk_sys_i) disable iff (rst_i)
    rail_startup_done_i && limit_source_internal_i |=> limit_sel_o == CSB_LIM_REGISTER;
  endproperty
  a_register_limit: assert property (p_register_limit) else $error("register limit");

  property p_pin_low;
    @(posedge clk_sys_i) disable iff (rst_i)
    rail_startup_done_i && !limit_source_internal_i && !limit_select_pin_i
      |=> limit_sel_o == CSB_LIM_PIN_LOW;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin low limit wrong");

  property p_charge_reduced;
    @(posedge clk_sys_i) disable iff (rst_i)
    system_rail_low_i && charge_priority_select_i |=> charge_mode_o == CSB_CHG_REDUCED;
  endproperty
  a_charge_reduced: assert property (p_charge_reduced) else $error("charge not reduced");

  property p_charge_full;
    @(posedge clk_sys_i) disable iff (rst_i)
    !system_rail_low_i |=> charge_mode_o == CSB_CHG_FULL;
  endproperty
  a_charge_full: assert property (p_charge_full) else $error("charge not full");

  property p_diode_on;
    @(posedge clk_sys_i) disable iff (rst_i)
    sys_below_bat_i |=> diode_switch_o && ext_diode_gate_pin_o;
  endproperty
  a_diode_on: assert property (p_diode_on) else $error("ideal diode not on");

  property p_prereg_run;
    @(posedge clk_sys_i) disable iff (rst_i)
    input_above_lockout_i |=> prereg_run_o;
  endproperty
  a_prereg_run: assert property (p_prereg_run) else $error("pre-regulator stopped");

  property p_rsvd_pulse;
    @(posedge clk_sys_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i >= CSB_RSVD_FIRST_OFS && reg_addr_i <= CSB_RSVD_LAST_OFS
      |=> reg_rsvd_wr_o;
  endproperty
  a_rsvd_pulse: assert property (p_rsvd_pulse) else $error("reserved write missed");

  property p_flags_reset;
    @(posedge clk_sys_i)
    rst_i |=> flags_q == CSB_FLAGS_RESET;
  endproperty
  a_flags_reset: assert property (p_flags_reset) else $error("flag reset value");

  property p_status_read;
    @(posedge clk_sys_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == CSB_STATUS_SECOND_OFS |=> reg_rdata_o == $past(status_second);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
endmodule
`default_nettype wire

/* tb/csb_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module csb_host_model (
  input wire logic clk_sys_i, // system clock
  input wire logic [7:0] reg_rdata_i, // read data from bank
  output logic [7:0] reg_addr_o, // register offset
  output logic reg_wr_o, // write strobe
  output logic reg_rd_o, // read strobe
  output logic [7:0] reg_wdata_o // write data
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // released bus shows the inverse of the last value, never a stale copy
  task automatic idle();
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
  // writes land only where the caller aims; no sweep of the reserved range
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_wr_o = 1'b0;
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
    idle();
  endtask
endmodule
`default_nettype wire

/* tb/test_csb_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module test_csb_bank;
  import csb_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] st = 8'h00;
  logic adp, lim, vin_ok, rdone, sbb, lsi, prio, pin, wr, rd, rsvd, irq, prereg, dsw, gate;
  logic [2:0] fld, lcode;
  logic [7:0] addr, wdata, rdata, sfirst, got;
  logic [1:0] lsel, cmode;
  logic [7:0] pat [7] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h40, 8'h80, 8'hff};
  logic [7:0] rsv [2] = '{8'h99, 8'h9f};
  int n_fail = 0;
  int n_compared = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  csb_host_model u_csb_host_model (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));
  csb_bank u_csb_bank (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rsvd_wr_o(rsvd), .adapter_present_i(adp), .input_limit_active_i(lim),
    .anti_swell_discharging_i(st[0]), .thermistor_check_disabled_i(st[1]),
    .charging_active_i(st[4]), .charge_complete_i(st[5]), .system_rail_low_i(st[6]),
    .die_overtemp_i(st[7]), .input_above_lockout_i(vin_ok), .rail_startup_done_i(rdone),
    .sys_below_bat_i(sbb), .limit_source_internal_i(lsi), .limit_setting_field_i(fld),
    .charge_priority_select_i(prio), .limit_select_pin_i(pin), .status_first_o(sfirst),
    .irq_o(irq), .limit_sel_o(lsel), .limit_code_o(lcode), .prereg_run_o(prereg),
    .charge_mode_o(cmode), .diode_switch_o(dsw), .ext_diode_gate_pin_o(gate));
  task automatic summarize();
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    u_csb_host_model.rd(a, got);
    chk(got, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  initial begin
    #(3000 * 50);
    n_fail++;
    summarize();
  end
  initial begin
    {adp, lim, vin_ok, rdone, sbb, lsi, prio, pin} = 8'h00;
    fld = 3'h5;
    step(10);
    rst_i = 1'b0;
    step(2);
    rd8(8'h97, 8'h00);
    rd8(8'h98, 8'h01);
    chk({7'h00, irq}, 8'h00);
    foreach (pat[i]) begin
      st = pat[i];
      rd8(8'h96, pat[i] & 8'hf3);
    end
    st = 8'h00;
    u_csb_host_model.wr(8'h96, 8'hff);
    rd8(8'h96, 8'h00);
    rd8(8'h9a, 8'h00);
    u_csb_host_model.wr(8'h97, 8'h07);
    rd8(8'h97, 8'h00);
    adp = 1'b1;
    step(1);
    chk(sfirst, 8'h01);
    step(2);
    rd8(8'h97, 8'h01);
    chk({7'h00, irq}, 8'h01);
    u_csb_host_model.wr(8'h97, 8'h00);
    rd8(8'h97, 8'h01);
    u_csb_host_model.wr(8'h97, 8'h01);
    rd8(8'h97, 8'h00);
    chk({7'h00, irq}, 8'h00);
    lim = 1'b1;
    step(1);
    chk(sfirst, 8'h81);
    step(2);
    rd8(8'h97, 8'h02);
    chk({7'h00, irq}, 8'h00);
    u_csb_host_model.wr(8'h98, 8'h03);
    step(2);
    chk({7'h00, irq}, 8'h01);
    u_csb_host_model.wr(8'h97, 8'h02);
    rd8(8'h97, 8'h00);
    st = 8'h20;
    step(3);
    rd8(8'h97, 8'h04);
    u_csb_host_model.wr(8'h97, 8'h04);
    st = 8'h00;
    step(3);
    rd8(8'h97, 8'h00);
    u_csb_host_model.wr(8'h98, 8'hff);
    rd8(8'h98, 8'hff);
    u_csb_host_model.wr(8'h97, 8'hf8);
    rd8(8'h97, 8'hf8);
    adp = 1'b0;
    step(3);
    fork
      u_csb_host_model.wr(8'h97, 8'hf9);
      begin
        step(1);
        adp = 1'b1;
      end
    join
    step(2);
    rd8(8'h97, 8'hf9);
    foreach (rsv[i]) begin
      u_csb_host_model.wr(rsv[i], 8'h00);
      chk({7'h00, rsvd}, 8'h01);
    end
    rd8(8'h98, 8'hff);
    lsi = 1'b1;
    step(2);
    chk({6'h00, lsel}, {6'h00, CSB_LIM_STARTUP});
    rdone = 1'b1;
    step(2);
    chk({lcode, 3'h0, lsel}, {3'h5, 3'h0, CSB_LIM_REGISTER});
    lsi = 1'b0;
    step(2);
    chk({6'h00, lsel}, {6'h00, CSB_LIM_PIN_LOW});
    pin = 1'b1;
    step(2);
    chk({6'h00, lsel}, {6'h00, CSB_LIM_PIN_HIGH});
    {vin_ok, sbb} = 2'h3;
    step(2);
    chk({5'h00, prereg, dsw, gate}, 8'h07);
    {vin_ok, sbb} = 2'h0;
    step(2);
    chk({5'h00, prereg, dsw, gate}, 8'h00);
    st = 8'h40;
    step(2);
    chk({6'h00, cmode}, {6'h00, CSB_CHG_OFF});
    prio = 1'b1;
    step(2);
    chk({6'h00, cmode}, {6'h00, CSB_CHG_REDUCED});
    lim = 1'b0;
    step(2);
    chk({6'h00, cmode}, {6'h00, CSB_CHG_REDUCED});
    st = 8'h00;
    step(2);
    chk({6'h00, cmode}, {6'h00, CSB_CHG_FULL});
    summarize();
  end
endmodule
`default_nettype wire
